/* mdscmd_pkg.sv */
// constants and types of the motion module settings command interpreter

package mdscmd_pkg;

	// ****************************************
	// command bytes
	// ****************************************
	localparam logic [7:0] CMD_WR_ACT  = 8'h44;
	localparam logic [7:0] CMD_RD_ACT  = 8'h64;
	localparam logic [7:0] CMD_WR_HYP  = 8'h45;
	localparam logic [7:0] CMD_RD_HYP  = 8'h65;
	localparam logic [7:0] CMD_WR_FREQ = 8'h46;
	localparam logic [7:0] CMD_RD_FREQ = 8'h66;
	localparam logic [7:0] CMD_WR_LVL  = 8'h47;
	localparam logic [7:0] CMD_RD_LVL  = 8'h67;
	localparam logic [7:0] CMD_WR_SUSP = 8'h48;
	localparam logic [7:0] CMD_RD_SUSP = 8'h68;
	localparam logic [7:0] CMD_RD_REV  = 8'h69;
	localparam logic [7:0] CMD_WR_MODE = 8'h4b;
	localparam logic [7:0] CMD_RD_MODE = 8'h6b;

	// ****************************************
	// argument and answer characters
	// ****************************************
	localparam logic [7:0] CH_Y    = 8'h59;
	localparam logic [7:0] CH_N    = 8'h4e;
	localparam logic [7:0] CH_L    = 8'h4c;
	localparam logic [7:0] CH_H    = 8'h48;
	localparam logic [7:0] CH_A    = 8'h41;
	localparam logic [7:0] CH_D    = 8'h44;
	localparam logic [7:0] CH_ZERO = 8'h30;
	localparam logic [7:0] CH_NINE = 8'h39;

	// ****************************************
	// values after reset
	// ****************************************
	localparam logic [7:0] ACT_TIME_RST  = 8'h00;
	localparam logic       HYPER_EN_RST  = 1'b0;
	localparam logic [1:0] HYPER_LVL_RST = 2'h1;
	localparam logic       FREQ_HIGH_RST = 1'b0;
	localparam logic       SUSPEND_RST   = 1'b0;
	localparam logic       ASCII_RST     = 1'b0;

	// ****************************************
	// value ranges and timing
	// ****************************************
	localparam logic [7:0]  ACT_NEVER_A  = 8'h00;
	localparam logic [7:0]  ACT_NEVER_B  = 8'h80;
	localparam logic [13:0] SEC_PER_MIN  = 14'h003c;
	localparam logic [9:0]  ARG_MAX      = 10'h0ff;
	localparam logic [9:0]  LVL_MAX      = 10'h003;
	localparam logic [1:0]  ASCII_LAST   = 2'h2;
	localparam int          CLK_PERIOD_NS = 50;
	localparam int          SECOND_NS     = 1000000000;
	localparam int          CYCLES_PER_SEC_DEF = SECOND_NS / CLK_PERIOD_NS;

	// ****************************************
	// apb register map
	// ****************************************
	localparam logic [7:0] ADDR_SETTINGS = 8'h00;
	localparam logic [7:0] ADDR_OVERRIDE = 8'h04;
	localparam logic [7:0] ADDR_REVISION = 8'h08;
	localparam int SET_ACT_LSB   = 0;
	localparam int SET_HYP_BIT   = 8;
	localparam int SET_LVL_LSB   = 9;
	localparam int SET_FREQ_BIT  = 11;
	localparam int SET_SUSP_BIT  = 12;
	localparam int SET_ASCII_BIT = 13;
	localparam int OVR_ACT_BIT   = 16;
	localparam int REV_ENG_LSB   = 8;

	// ****************************************
	// types
	// ****************************************
	typedef enum logic [1:0] {ST_IDLE, ST_ARG, ST_SEND} mdscmd_fsm_t;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} mdscmd_apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} mdscmd_apb_rsp_t;

	typedef struct packed {
		logic [7:0] act_time;
		logic       hyper_en;
		logic [1:0] hyper_lvl;
		logic       freq_high;
		logic       suspend;
		logic       ascii;
	} mdscmd_settings_t;

	typedef struct packed {
		mdscmd_fsm_t      fsm;
		mdscmd_settings_t set;
		logic [7:0]       cmd;
		logic [9:0]       arg_acc;
		logic [1:0]       arg_cnt;
		logic             arg_bad;
		logic [7:0]       resp_v0;
		logic [7:0]       resp_v1;
		logic             resp_two;
		logic             resp_chr;
		logic             resp_ascii;
		logic [2:0]       byte_idx;
		logic             tx_valid;
		logic [7:0]       tx_data;
		logic [31:0]      prescale;
		logic [13:0]      remain_s;
		logic             md_out;
		logic [1:0]       eff_lvl;
		mdscmd_apb_rsp_t  rsp;
	} mdscmd_state_t;

endpackage

/* mdscmd_top.sv */
// settings command interpreter with activation timer and apb status port
`timescale 1ns/100ps
`default_nettype none

module mdscmd_top import mdscmd_pkg::*; #(
	parameter int         CYCLES_PER_SEC = CYCLES_PER_SEC_DEF,
	parameter logic [7:0] APP_REV        = 8'h01, // arbitrary value
	parameter logic [7:0] ENGINE_REV     = 8'h01  // arbitrary value
) (
	// clock and reset
	input  wire logic            clk_sys,
	input  wire logic            arst_n,
	// apb slave
	input  wire mdscmd_apb_req_t apb_req,
	output var  mdscmd_apb_rsp_t apb_rsp,
	// received command bytes from the serial framer
	input  wire logic [7:0]      rx_data,
	input  wire logic            rx_valid,
	// answer bytes to the serial framer
	output logic [7:0]           tx_data,
	output logic                 tx_valid,
	input  wire logic            tx_ready,
	// detection engine
	input  wire logic            motion_event,
	output logic [1:0]           hyper_level_eff,
	output logic                 freq_high,
	output logic                 detect_suspend,
	// motion output, active high
	output logic                 motion_indicator_output
);

	// ****************************************
	// elaboration checks
	// ****************************************
	if (CYCLES_PER_SEC < 2) begin : g_chk
		$error("CYCLES_PER_SEC must be at least 2");
	end

	localparam logic [31:0] PRESCALE_LAST = 32'(CYCLES_PER_SEC - 1);

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [13:0] act_secs(input logic [7:0] v);
		logic [13:0] s;
		s = 14'h0000;
		if (v == ACT_NEVER_A || v == ACT_NEVER_B) begin
			s = 14'h0000;
		end else if (!v[7]) begin
			s = {6'h00, v};
		end else begin
			s = 14'({7'h00, v[6:0]} * SEC_PER_MIN);
		end
		return s;
	endfunction

	// one answer byte from up to two latched values
	function automatic logic [7:0] resp_byte(
		input logic [7:0] v0,
		input logic [7:0] v1,
		input logic       chr,
		input logic       asc,
		input logic [2:0] idx
	);
		logic [7:0] v;
		logic [7:0] d;
		logic [2:0] pos;
		v   = (idx < 3'h3) ? v0 : v1;
		pos = (idx < 3'h3) ? idx : 3'(idx - 3'h3);
		d   = 8'h00;
		if (chr) begin
			return v0;
		end
		if (!asc) begin
			return (idx == 3'h0) ? v0 : v1;
		end
		case (pos)
			3'h0:    d = v / 8'h64;
			3'h1:    d = (v / 8'h0a) % 8'h0a;
			default: d = v % 8'h0a;
		endcase
		return 8'(CH_ZERO + d);
	endfunction

	function automatic logic [2:0] resp_last(
		input logic chr,
		input logic asc,
		input logic two
	);
		if (chr) begin
			return 3'h0;
		end
		if (asc) begin
			return two ? 3'h5 : 3'h2;
		end
		return two ? 3'h1 : 3'h0;
	endfunction

	// ****************************************
	// state
	// ****************************************
	mdscmd_state_t st;
	mdscmd_state_t next_st;

	logic is_digit;
	assign is_digit = (rx_data >= CH_ZERO) && (rx_data <= CH_NINE);

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		logic       numeric;
		logic [9:0] acc;
		logic       bad;
		logic       commit;
		logic [7:0] cv;
		logic       apb_acc;
		logic [13:0] ovr_s;
		numeric = 1'b0;
		acc     = 10'h000;
		bad     = 1'b0;
		commit  = 1'b0;
		cv      = 8'h00;
		apb_acc = 1'b0;
		ovr_s   = 14'h0000;
		next_st = st;

		// command parser
		case (st.fsm)
			ST_IDLE: begin
				if (rx_valid) begin
					next_st.cmd      = rx_data;
					next_st.arg_acc  = 10'h000;
					next_st.arg_cnt  = 2'h0;
					next_st.arg_bad  = 1'b0;
					next_st.resp_v1  = ENGINE_REV;
					next_st.resp_two = 1'b0;
					next_st.resp_chr = 1'b1;
					next_st.resp_ascii = st.set.ascii;
					next_st.byte_idx = 3'h0;
					next_st.fsm      = ST_SEND;
					case (rx_data)
						CMD_WR_ACT, CMD_WR_HYP, CMD_WR_FREQ,
						CMD_WR_LVL, CMD_WR_SUSP, CMD_WR_MODE: begin
							next_st.fsm = ST_ARG;
						end
						CMD_RD_ACT: begin
							next_st.resp_v0  = st.set.act_time;
							next_st.resp_chr = 1'b0;
						end
						CMD_RD_HYP: begin
							next_st.resp_v0 = st.set.hyper_en ? CH_Y : CH_N;
						end
						CMD_RD_FREQ: begin
							next_st.resp_v0 = st.set.freq_high ? CH_H : CH_L;
						end
						CMD_RD_LVL: begin
							next_st.resp_v0  = {6'h00, st.set.hyper_lvl};
							next_st.resp_chr = 1'b0;
						end
						CMD_RD_SUSP: begin
							next_st.resp_v0 = st.set.suspend ? CH_Y : CH_N;
						end
						CMD_RD_REV: begin
							next_st.resp_v0  = APP_REV;
							next_st.resp_two = 1'b1;
							next_st.resp_chr = 1'b0;
						end
						CMD_RD_MODE: begin
							next_st.resp_v0 = st.set.ascii ? CH_A : CH_D;
						end
						default: begin
							next_st.fsm = ST_IDLE;
						end
					endcase
					if (next_st.fsm == ST_SEND) begin
						next_st.tx_valid = 1'b1;
						next_st.tx_data  = resp_byte(next_st.resp_v0, next_st.resp_v1,
							next_st.resp_chr, st.set.ascii, 3'h0);
					end
				end
			end
			ST_ARG: begin
				numeric = (st.cmd == CMD_WR_ACT) || (st.cmd == CMD_WR_LVL);
				if (rx_valid) begin
					if (numeric && st.set.ascii) begin
						// three digits, leading zeros; anything else spoils it
						bad = st.arg_bad || !is_digit;
						acc = 10'(st.arg_acc * 10'h00a + {6'h00, rx_data[3:0]});
						next_st.arg_acc = acc;
						next_st.arg_bad = bad;
						next_st.arg_cnt = 2'(st.arg_cnt + 2'h1);
						if (st.arg_cnt == ASCII_LAST) begin
							commit = !bad && (acc <= ARG_MAX);
							cv     = acc[7:0];
							next_st.fsm = ST_IDLE;
						end
					end else begin
						commit = 1'b1;
						cv     = rx_data;
						acc    = {2'h0, rx_data};
						next_st.fsm = ST_IDLE;
					end
				end
				if (commit) begin
					case (st.cmd)
						CMD_WR_ACT: begin
							next_st.set.act_time = cv;
						end
						CMD_WR_LVL: begin
							if (acc <= LVL_MAX) begin
								next_st.set.hyper_lvl = cv[1:0];
							end
						end
						CMD_WR_HYP: begin
							if (cv == CH_Y || cv == CH_N) begin
								next_st.set.hyper_en = (cv == CH_Y);
							end
						end
						CMD_WR_FREQ: begin
							if (cv == CH_H || cv == CH_L) begin
								next_st.set.freq_high = (cv == CH_H);
							end
						end
						CMD_WR_SUSP: begin
							if (cv == CH_Y || cv == CH_N) begin
								next_st.set.suspend = (cv == CH_Y);
							end
						end
						CMD_WR_MODE: begin
							if (cv == CH_A || cv == CH_D) begin
								next_st.set.ascii = (cv == CH_A);
							end
						end
						default: begin
							next_st.set = st.set;
						end
					endcase
				end
			end
			ST_SEND: begin
				// bytes arriving while answering are dropped, there is no buffer
				if (tx_ready) begin
					if (st.byte_idx == resp_last(st.resp_chr, st.resp_ascii, st.resp_two)) begin
						next_st.tx_valid = 1'b0;
						next_st.fsm      = ST_IDLE;
					end else begin
						next_st.byte_idx = 3'(st.byte_idx + 3'h1);
						next_st.tx_data  = resp_byte(st.resp_v0, st.resp_v1, st.resp_chr,
							st.resp_ascii, 3'(st.byte_idx + 3'h1));
					end
				end
			end
			default: begin
				next_st.fsm = ST_IDLE;
			end
		endcase

		// ****************************************
		// activation timer
		// ****************************************
		if (st.remain_s != 14'h0000) begin
			if (st.prescale == PRESCALE_LAST) begin
				next_st.prescale = 32'h00000000;
				next_st.remain_s = 14'(st.remain_s - 14'h0001);
			end else begin
				next_st.prescale = 32'(st.prescale + 32'h00000001);
			end
		end else begin
			next_st.prescale = 32'h00000000;
		end
		// motion restarts the hold, also over a manual one
		if (motion_event && !st.set.suspend && act_secs(st.set.act_time) != 14'h0000) begin
			next_st.remain_s = act_secs(st.set.act_time);
			next_st.prescale = 32'h00000000;
		end

		// ****************************************
		// apb slave, one wait state
		// ****************************************
		apb_acc = apb_req.psel && apb_req.penable;
		// answer stands one cycle only; a stale error must not linger past pready
		next_st.rsp.pready  = apb_acc && !st.rsp.pready;
		next_st.rsp.prdata  = 32'h00000000;
		next_st.rsp.pslverr = 1'b0;
		if (apb_acc && !st.rsp.pready) begin
			if (apb_req.paddr == ADDR_SETTINGS) begin
				next_st.rsp.prdata[SET_ACT_LSB +: 8]   = st.set.act_time;
				next_st.rsp.prdata[SET_HYP_BIT]        = st.set.hyper_en;
				next_st.rsp.prdata[SET_LVL_LSB +: 2]   = st.set.hyper_lvl;
				next_st.rsp.prdata[SET_FREQ_BIT]       = st.set.freq_high;
				next_st.rsp.prdata[SET_SUSP_BIT]       = st.set.suspend;
				next_st.rsp.prdata[SET_ASCII_BIT]      = st.set.ascii;
			end else if (apb_req.paddr == ADDR_OVERRIDE) begin
				next_st.rsp.prdata[13:0]        = st.remain_s;
				next_st.rsp.prdata[OVR_ACT_BIT] = st.md_out;
			end else if (apb_req.paddr == ADDR_REVISION) begin
				next_st.rsp.prdata[7:0]                = APP_REV;
				next_st.rsp.prdata[REV_ENG_LSB +: 8]   = ENGINE_REV;
			end else begin
				next_st.rsp.pslverr = 1'b1;
			end
		end
		// write takes effect on the completing edge; works even while suspended
		if (apb_acc && st.rsp.pready && apb_req.pwrite && apb_req.paddr == ADDR_OVERRIDE) begin
			ovr_s = act_secs(apb_req.pwdata[7:0]);
			next_st.remain_s = ovr_s;
			next_st.prescale = 32'h00000000;
		end

		next_st.md_out  = (next_st.remain_s != 14'h0000);
		// level 0 or mode off both give no extra sensitivity
		next_st.eff_lvl = next_st.set.hyper_en ? next_st.set.hyper_lvl : 2'h0;
	end

	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			st                <= '0;
			st.fsm            <= ST_IDLE;
			st.set.act_time   <= ACT_TIME_RST;
			st.set.hyper_en   <= HYPER_EN_RST;
			st.set.hyper_lvl  <= HYPER_LVL_RST;
			st.set.freq_high  <= FREQ_HIGH_RST;
			st.set.suspend    <= SUSPEND_RST;
			st.set.ascii      <= ASCII_RST;
			st.eff_lvl        <= 2'h0;
		end else begin
			st <= next_st;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign apb_rsp                 = st.rsp;
	assign tx_data                 = st.tx_data;
	assign tx_valid                = st.tx_valid;
	assign hyper_level_eff         = st.eff_lvl;
	assign freq_high               = st.set.freq_high;
	assign detect_suspend          = st.set.suspend;
	assign motion_indicator_output = st.md_out;

endmodule

`default_nettype wire

/* mdscmd_props.sv */
// concurrent checks on the ports of the settings command interpreter
`timescale 1ns/100ps
`default_nettype none

module mdscmd_props import mdscmd_pkg::*; (
	// clock and reset
	input wire logic            clk_sys,
	input wire logic            arst_n,
	// apb
	input wire mdscmd_apb_req_t apb_req,
	input wire mdscmd_apb_rsp_t apb_rsp,
	// serial bytes
	input wire logic [7:0]      rx_data,
	input wire logic            rx_valid,
	input wire logic [7:0]      tx_data,
	input wire logic            tx_valid,
	input wire logic            tx_ready,
	// detection engine
	input wire logic            motion_event,
	input wire logic [1:0]      hyper_level_eff,
	input wire logic            freq_high,
	input wire logic            detect_suspend,
	input wire logic            motion_indicator_output
);
	// ******************
	// properties
	// ******************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!arst_n);

	a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
		else $error("answer byte changed before taken");
	a_tx_cause: assert property ($rose(tx_valid) |-> $past(rx_valid))
		else $error("answer without command byte");
	a_apb_wait: assert property (apb_req.psel && apb_req.penable && !apb_rsp.pready
		|=> apb_rsp.pready)
		else $error("no ready after one wait state");
	a_ready_one: assert property (apb_rsp.pready |=> !apb_rsp.pready)
		else $error("ready longer than one cycle");
	a_err_zero: assert property (apb_rsp.pslverr |-> apb_rsp.pready && apb_rsp.prdata == 32'h0)
		else $error("error response malformed");
	// settings outputs may only move shortly after a received argument
	a_freq_cause: assert property ($changed(freq_high)
		|-> $past(rx_valid) || $past(rx_valid, 2) || $past(rx_valid, 3))
		else $error("frequency output moved without command");
	a_susp_cause: assert property ($changed(detect_suspend)
		|-> $past(rx_valid) || $past(rx_valid, 2) || $past(rx_valid, 3))
		else $error("suspend output moved without command");
	a_lvl_cause: assert property ($changed(hyper_level_eff)
		|-> $past(rx_valid) || $past(rx_valid, 2) || $past(rx_valid, 3))
		else $error("level output moved without command");
	a_susp_block: assert property (detect_suspend && motion_event && !motion_indicator_output
		&& !apb_req.psel && !$past(rx_valid) |=> !motion_indicator_output)
		else $error("motion raised output while suspended");
endmodule

`default_nettype wire

/* mdscmd_host.sv */
// host model: sends command bytes, takes answers with random stalls
`timescale 1ns/100ps
`default_nettype none

module mdscmd_host (
	// clock
	input  wire logic       clk_sys,
	// bytes to the block
	output logic [7:0]      rx_data,
	output logic            rx_valid,
	// answers from the block
	input  wire logic [7:0] tx_data,
	input  wire logic       tx_valid,
	output logic            tx_ready
);
	logic [7:0] rxq [$];

	initial begin
		rx_data = 8'h00;
		rx_valid = 1'b0;
		tx_ready = 1'b0;
	end

	// arguments are built by the caller as one byte or three digits
	task automatic send(input logic [7:0] b);
		@(posedge clk_sys);
		rx_data <= b;
		rx_valid <= 1'b1;
		@(posedge clk_sys);
		rx_valid <= 1'b0;
		// stale byte inverted so an idle line never looks valid
		rx_data <= ~b;
	endtask

	always @(posedge clk_sys) begin
		if (tx_valid && tx_ready)
			rxq.push_back(tx_data);
		tx_ready <= 1'($urandom_range(1, 0));
	end
endmodule

`default_nettype wire

/* mdscmd_top_tb.sv */
// self-checking bench of the settings command interpreter
`timescale 1ns/100ps
`default_nettype none

module mdscmd_top_tb import mdscmd_pkg::*;;
	// ******************
	// setup
	// ******************
	localparam int         CPS   = 4;
	localparam logic [7:0] APP_R = 8'h3a; // arbitrary value
	localparam logic [7:0] ENG_R = 8'hc5; // arbitrary value
	localparam logic [7:0] CODES [4] = '{8'h00, 8'h80, 8'h03, 8'h81};
	localparam logic [7:0] WCMD [6] = '{CMD_WR_ACT, CMD_WR_LVL, CMD_WR_HYP,
		CMD_WR_FREQ, CMD_WR_SUSP, CMD_WR_MODE};
	localparam logic [7:0] CHA [6] = '{8'h00, 8'h00, CH_Y, CH_H, CH_Y, CH_A};
	localparam logic [7:0] CHB [6] = '{8'h00, 8'h00, CH_N, CH_L, CH_N, CH_D};
	logic            clk_sys = 1'b0;
	logic            arst_n = 1'b0;
	mdscmd_apb_req_t apb_req = '0;
	mdscmd_apb_rsp_t apb_rsp;
	logic [7:0]      rx_data, tx_data, m_act, v;
	logic            rx_valid, tx_valid, tx_ready, freq_high, detect_suspend;
	logic            motion_event = 1'b0;
	logic            motion_indicator_output, m_hen, m_fh, m_sus, m_asc, e;
	logic [1:0]      hyper_level_eff, m_lvl;
	logic [31:0]     d;
	int              err_total = 0;
	int              total_checks = 0;
	int              cyc = 0;
	int              k, s;

	always #25 clk_sys = ~clk_sys;

	mdscmd_top #(.CYCLES_PER_SEC(CPS), .APP_REV(APP_R), .ENGINE_REV(ENG_R)) mdscmd_top_i (
		.clk_sys, .arst_n, .apb_req, .apb_rsp, .rx_data, .rx_valid, .tx_data, .tx_valid,
		.tx_ready, .motion_event, .hyper_level_eff, .freq_high, .detect_suspend,
		.motion_indicator_output);
	mdscmd_host mdscmd_host_i (.clk_sys, .rx_data, .rx_valid, .tx_data, .tx_valid, .tx_ready);

	// ******************
	// tasks
	// ******************
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic final_report();
		if (err_total == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	function automatic logic [7:0] dig(input logic [7:0] x, input int p);
		return 8'(CH_ZERO + (x / p) % 10);
	endfunction

	task automatic do_reset();
		arst_n <= 1'b0;
		repeat (6) @(posedge clk_sys);
		arst_n <= 1'b1;
		m_act = ACT_TIME_RST;
		m_hen = HYPER_EN_RST;
		m_lvl = HYPER_LVL_RST;
		m_fh = FREQ_HIGH_RST;
		m_sus = SUSPEND_RST;
		m_asc = ASCII_RST;
	endtask

	// waits for pready however long; only the cycle ceiling ends a hang
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		@(posedge clk_sys);
		apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: wd};
		@(posedge clk_sys);
		apb_req.penable <= 1'b1;
		do begin
			@(posedge clk_sys);
		end while (apb_rsp.pready !== 1'b1);
		d = apb_rsp.prdata;
		e = apb_rsp.pslverr;
		apb_req <= '0;
	endtask

	task automatic wr(input logic [7:0] c, input logic [7:0] x, input logic num);
		mdscmd_host_i.send(c);
		if (num && m_asc)
			for (int p = 100; p > 0; p /= 10) mdscmd_host_i.send(dig(x, p));
		else
			mdscmd_host_i.send(x);
		repeat (3) @(posedge clk_sys);
	endtask

	// nv zero: one character answer, else count of numeric values
	task automatic rd(input logic [7:0] c, input logic [7:0] v0, input logic [7:0] v1, input int nv);
		logic [7:0] q [$];
		int         n;
		q = {};
		if (nv == 0)
			q.push_back(v0);
		for (int i = 0; i < nv; i++)
			if (m_asc) for (int p = 100; p > 0; p /= 10) q.push_back(dig(i ? v1 : v0, p));
			else q.push_back(i ? v1 : v0);
		mdscmd_host_i.rxq.delete();
		mdscmd_host_i.send(c);
		n = 0;
		while (mdscmd_host_i.rxq.size() < q.size() && n < 300) begin
			@(posedge clk_sys);
			n++;
		end
		repeat (4) @(posedge clk_sys);
		chk(mdscmd_host_i.rxq.size(), q.size());
		foreach (q[i]) chk(mdscmd_host_i.rxq[i], q[i]);
	endtask

	task automatic chk_all();
		rd(CMD_RD_ACT, m_act, 8'h00, 1);
		rd(CMD_RD_HYP, m_hen ? CH_Y : CH_N, 8'h00, 0);
		rd(CMD_RD_LVL, {6'h00, m_lvl}, 8'h00, 1);
		rd(CMD_RD_FREQ, m_fh ? CH_H : CH_L, 8'h00, 0);
		rd(CMD_RD_SUSP, m_sus ? CH_Y : CH_N, 8'h00, 0);
		rd(CMD_RD_MODE, m_asc ? CH_A : CH_D, 8'h00, 0);
		rd(CMD_RD_REV, APP_R, ENG_R, 2);
		chk(hyper_level_eff, m_hen ? m_lvl : 2'h0);
		chk(freq_high, m_fh);
		chk(detect_suspend, m_sus);
		apb(1'b0, ADDR_SETTINGS, 32'h0);
		chk(d, {18'h0, m_asc, m_sus, m_fh, m_lvl, m_hen, m_act});
	endtask

	task automatic pulse();
		@(posedge clk_sys);
		motion_event <= 1'b1;
		@(posedge clk_sys);
		motion_event <= 1'b0;
		@(posedge clk_sys);
	endtask

	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			err_total++;
			final_report();
		end
	end

	// ******************
	// scenarios
	// ******************
	initial begin
		void'($urandom(32'h5e49d968));
		do_reset();
		chk_all();
		apb(1'b1, ADDR_SETTINGS, 32'hffffffff);
		apb(1'b0, 8'h0c, 32'h0);
		chk(e, 1'b1);
		chk(d, 32'h0);
		apb(1'b0, ADDR_REVISION, 32'h0);
		chk(d, {16'h0, ENG_R, APP_R});
		chk(e, 1'b0);
		wr(CMD_WR_HYP, CH_Y, 1'b0);
		wr(CMD_WR_LVL, 8'h03, 1'b1);
		m_hen = 1'b1;
		m_lvl = 2'h3;
		chk(hyper_level_eff, 2'h3);
		wr(CMD_WR_LVL, 8'h00, 1'b1);
		m_lvl = 2'h0;
		chk(hyper_level_eff, 2'h0);
		foreach (CODES[i]) begin
			wr(CMD_WR_ACT, CODES[i], 1'b1);
			m_act = CODES[i];
			pulse();
			apb(1'b0, ADDR_OVERRIDE, 32'h0);
			s = CODES[i][7] ? (CODES[i] - 128) * 60 : CODES[i];
			chk(motion_indicator_output, s != 0);
			chk(d[16], s != 0);
			chk(d[13:0] <= s && d[13:0] + 1 >= s, 1'b1);
			repeat (3 * CPS + 4) @(posedge clk_sys);
			if (s < 60)
				chk(motion_indicator_output, 1'b0);
			apb(1'b1, ADDR_OVERRIDE, 32'h0);
		end
		wr(CMD_WR_SUSP, CH_Y, 1'b0);
		m_sus = 1'b1;
		pulse();
		chk(motion_indicator_output, 1'b0);
		// two seconds, so only the clearing write can drop the output below
		apb(1'b1, ADDR_OVERRIDE, 32'h2);
		@(posedge clk_sys);
		chk(motion_indicator_output, 1'b1);
		apb(1'b1, ADDR_OVERRIDE, 32'h0);
		@(posedge clk_sys);
		chk(motion_indicator_output, 1'b0);
		chk_all();
		// valid and refused arguments mixed; refused ones must change nothing
		for (int j = 0; j < 40; j++) begin
			k = $urandom_range(5, 0);
			s = $urandom_range(2, 0);
			v = (k == 1) ? 8'($urandom_range(5, 0)) : 8'($urandom);
			if (k > 1)
				v = s == 0 ? CHA[k] : s == 1 ? CHB[k] : 8'h7a;
			wr(WCMD[k], v, k < 2);
			case (k)
				0: m_act = v;
				1: if (v <= 8'h03) m_lvl = v[1:0];
				2: if (v == CH_Y || v == CH_N) m_hen = v == CH_Y;
				3: if (v == CH_H || v == CH_L) m_fh = v == CH_H;
				4: if (v == CH_Y || v == CH_N) m_sus = v == CH_Y;
				default: if (v == CH_A || v == CH_D) m_asc = v == CH_A;
			endcase
			chk_all();
		end
		do_reset();
		chk_all();
		final_report();
	end
endmodule

bind mdscmd_top mdscmd_props mdscmd_props_i (.clk_sys, .arst_n, .apb_req, .apb_rsp, .rx_data,
	.rx_valid, .tx_data, .tx_valid, .tx_ready, .motion_event, .hyper_level_eff, .freq_high,
	.detect_suspend, .motion_indicator_output);

`default_nettype wire
